// ---- hdl/cfstl_top.sv ----
// How it works
// - analog bad outside sensor failure limits
// - clamp enable: bad after four seconds outside
// - high/low limited beyond range limits
// - bad-if-limited option makes limited block bad
// - only masked diagnostics make field value bad
// - discrete input bad on circuit or wiring
// - bad command starts timer, trips at limit
// - fault state drives the output off
// - timer limit resets to 300 seconds
// - 1oo2/2oo3 tolerate one bad input
// - bad cause makes mapped effects bad
// - status option changes value, not status
// - channel fault gives bad status and annunciation
// - input faults never force outputs off
// - stuck-on readback after off opens master
// - wiring check pulses output off each period
// - open/short gives bad, sensor-fail, low-limited
// - channel status detection trips immediately
// - channel status detection enabled at reset
// - fault state clears once channel diagnostic goes quiet
//
// Implementation choices: the AHB-Lite slave port and the address map.
`timescale 1ns/1ps
module cfstl_top
    import cfstl_pkg::*;
#(
    parameter int unsigned TICK_LEN = TICK_CYCLES
) (
    input  wire logic        clk,
    input  wire logic        sys_rst,
    input  wire logic        ce,
    // ahb-lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    // analog input channel
    input  wire logic [15:0] ai_current_ua,
    input  wire logic [15:0] ai_value_pct,
    input  wire logic [7:0]  field_diag,
    // discrete input channel
    input  wire logic        di_circuit_fault,
    input  wire logic        di_wire_fault,
    // voter and matrix inputs
    input  wire logic [2:0]  vote_trip,
    input  wire logic [2:0]  vote_bad,
    input  wire logic [3:0]  cause_trip,
    // output block
    input  wire logic        cmd_value,
    input  wire logic        cmd_bad,
    input  wire logic        do_open,
    input  wire logic        do_short,
    input  wire logic        do_readback,
    output cfstl_ai_stat_s   ai_status,
    output logic             ai_block_bad,
    output logic             field_value_bad,
    output logic             di_bad,
    output logic             voter_out,
    output logic             voter_bad,
    output logic      [3:0]  effect_out,
    output logic      [3:0]  effect_bad,
    output cfstl_do_stat_s   do_status,
    output logic             do_out,
    output logic             master_power_en,
    output logic             annunciate
);

    // ------------------------------------------------------------
    // registers and internal state
    // ------------------------------------------------------------
    logic [CTRL_W-1:0] ctrl;
    logic [15:0]       hi_pct;
    logic [15:0]       lo_pct;
    logic [7:0]        field_diag_mask;
    logic [31:0]       fault_timer_limit;
    logic [31:0]       fault_timer_count;
    logic [15:0]       cem_map;
    logic              stuck_on;
    logic              master_open;
    logic              fault_state;
    logic              off_settled;
    logic [31:0]       tick_cnt;
    logic              tick;
    logic [15:0]       clamp_cnt;
    logic [7:0]        pulse_cnt;
    logic              pulse_off;
    logic              wr_pend;
    logic [7:0]        wr_addr;
    logic [1:0]        fso;
    logic              chan_fault;
    logic [3:0]        cause_bad;
    logic [31:0]       rd_mux;
    logic [31:0]       status_word;
    logic              bus_take;
    logic              sensor_out;
    logic              clamp_out;
    logic              diag_hit;
    logic              lim_hi;
    logic              lim_lo;
    logic [1:0]        n_trip;
    logic [1:0]        n_bad;
    cfstl_vote_e       vmode;

    assign fso        = ctrl[CTRL_FSO_LO+1:CTRL_FSO_LO];
    assign vmode      = cfstl_vote_e'(ctrl[CTRL_VMODE_LO+1:CTRL_VMODE_LO]);
    assign chan_fault = do_open | do_short;
    assign bus_take   = hsel & htrans[1] & hready;

    // ------------------------------------------------------------
    // millisecond tick shared by all timers
    // ------------------------------------------------------------
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            tick_cnt <= 32'h0;
            tick     <= 1'b0;
        end else if (ce) begin
            tick     <= (tick_cnt == 32'(TICK_LEN - 1));
            tick_cnt <= (tick_cnt == 32'(TICK_LEN - 1)) ? 32'h0 : tick_cnt + 32'h1;
        end
    end

    // ------------------------------------------------------------
    // ahb-lite slave: zero wait states, registered read data
    // ------------------------------------------------------------
    assign status_word = {17'h0, master_open, stuck_on, fault_state, do_status,
                          effect_bad, voter_bad, di_bad, ai_status};

    // unmapped offsets read as zero and ignore writes
    always_comb begin
        case (haddr[7:0])
            REG_CTRL:      rd_mux = {{(32-CTRL_W){1'b0}}, ctrl};
            REG_RANGE:     rd_mux = {lo_pct, hi_pct};
            REG_DIAG_MASK: rd_mux = {24'h0, field_diag_mask};
            REG_FT_LIMIT:  rd_mux = fault_timer_limit;
            REG_CEM_MAP:   rd_mux = {16'h0, cem_map};
            REG_STATUS:    rd_mux = status_word;
            REG_FT_COUNT:  rd_mux = fault_timer_count;
            default:       rd_mux = 32'h0;
        endcase
    end

    // address phase latch, read data ready for the data phase
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            wr_pend   <= 1'b0;
            wr_addr   <= 8'h0;
            hrdata    <= 32'h0;
            hreadyout <= 1'b0;
            hresp     <= 1'b0;
        end else if (ce) begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
            wr_pend   <= bus_take & hwrite & (haddr[31:8] == 24'h0);
            wr_addr   <= haddr[7:0];
            if (bus_take && !hwrite) begin
                hrdata <= (haddr[31:8] == 24'h0) ? rd_mux : 32'h0;
            end
        end
    end

    // software-written configuration
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            ctrl              <= CTRL_RST;
            hi_pct            <= HI_PCT_RST;
            lo_pct            <= LO_PCT_RST;
            field_diag_mask   <= DIAG_MASK_RST;
            fault_timer_limit <= FT_LIMIT_RST;
            cem_map           <= CEM_MAP_RST;
        end else if (ce && wr_pend) begin
            case (wr_addr)
                REG_CTRL:      ctrl              <= hwdata[CTRL_W-1:0];
                REG_RANGE:     {lo_pct, hi_pct}  <= hwdata;
                REG_DIAG_MASK: field_diag_mask   <= hwdata[7:0];
                REG_FT_LIMIT:  fault_timer_limit <= hwdata;
                REG_CEM_MAP:   cem_map           <= hwdata[15:0];
                default:       ;
            endcase
        end
    end

    // ------------------------------------------------------------
    // analog input channel
    // ------------------------------------------------------------
    assign sensor_out = (ai_current_ua < SENSOR_LO_UA) | (ai_current_ua > SENSOR_HI_UA);
    assign clamp_out  = (ai_current_ua < CLAMP_LO_UA) | (ai_current_ua > CLAMP_HI_UA);
    assign diag_hit   = |(field_diag & field_diag_mask);
    assign lim_hi     = $signed(ai_value_pct) > $signed(hi_pct);
    assign lim_lo     = $signed(ai_value_pct) < $signed(lo_pct);

    // clamp qualification counts whole milliseconds spent outside
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            clamp_cnt <= 16'h0;
        end else if (ce) begin
            if (!clamp_out || !ctrl[CTRL_CLAMP_EN]) begin
                clamp_cnt <= 16'h0;
            end else if (tick && clamp_cnt != 16'(CLAMP_QUAL_MS)) begin
                clamp_cnt <= clamp_cnt + 16'h1;
            end
        end
    end

    // channel and block status
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            ai_status       <= '0;
            ai_block_bad    <= 1'b0;
            field_value_bad <= 1'b0;
        end else if (ce) begin
            ai_status.bad      <= sensor_out | (clamp_cnt == 16'(CLAMP_QUAL_MS));
            ai_status.high_lim <= lim_hi;
            ai_status.low_lim  <= lim_lo;
            field_value_bad    <= diag_hit;
            ai_block_bad       <= ai_status.bad | (ctrl[CTRL_BAD_LIM] &
                                  (ai_status.high_lim | ai_status.low_lim));
        end
    end

    // ------------------------------------------------------------
    // discrete input channel
    // ------------------------------------------------------------
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            di_bad <= 1'b0;
        end else if (ce) begin
            di_bad <= di_circuit_fault | (ctrl[CTRL_DI_WIRE] & di_wire_fault);
        end
    end

    // ------------------------------------------------------------
    // voter: status fixed by mode, option only moves the value
    // ------------------------------------------------------------
    always_comb begin
        n_trip = 2'h0;
        n_bad  = 2'h0;
        for (int i = 0; i < 3; i++) begin
            // option set: a bad input counts as a trip vote
            n_trip = n_trip + 2'(vote_trip[i] | (ctrl[CTRL_VSOPT] & vote_bad[i]));
            n_bad  = n_bad + 2'(vote_bad[i]);
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            voter_out <= 1'b0;
            voter_bad <= 1'b0;
        end else if (ce) begin
            case (vmode)
                VOTE_1OO1: begin
                    voter_out <= n_trip >= 2'h1;
                    voter_bad <= vote_bad[0];
                end
                VOTE_1OO2: begin
                    voter_out <= n_trip >= 2'h1;
                    voter_bad <= &vote_bad[1:0];
                end
                VOTE_2OO2: begin
                    voter_out <= n_trip >= 2'h2;
                    voter_bad <= |vote_bad[1:0];
                end
                VOTE_2OO3: begin
                    voter_out <= n_trip >= 2'h2;
                    voter_bad <= n_bad >= 2'h2;
                end
                default: begin
                    voter_out <= 1'b0;
                    voter_bad <= 1'b0;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // cause-effect matrix: bit 4*e+c maps cause c to effect e
    // ------------------------------------------------------------
    assign cause_bad = {1'b0, voter_bad, di_bad, ai_block_bad};

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            effect_out <= 4'h0;
            effect_bad <= 4'h0;
        end else if (ce) begin
            for (int e = 0; e < 4; e++) begin
                effect_bad[e] <= |(cem_map[4*e +: 4] & cause_bad);
                effect_out[e] <= |(cem_map[4*e +: 4] &
                                  (cause_trip | (cause_bad & {4{ctrl[CTRL_VSOPT]}})));
            end
        end
    end

    // ------------------------------------------------------------
    // output block fault timer, milliseconds
    // ------------------------------------------------------------
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            fault_timer_count <= 32'h0;
        end else if (ce) begin
            if (!cmd_bad) begin
                fault_timer_count <= 32'h0;
            end else if (tick && fault_timer_count < fault_timer_limit) begin
                fault_timer_count <= fault_timer_count + 32'h1;
            end
        end
    end

    // fault state follows its causes, so an off channel whose
    // diagnostic goes quiet leaves the fault state by itself
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            fault_state <= 1'b0;
        end else if (ce) begin
            fault_state <= (fso[FSO_CMD] & cmd_bad &
                            (fault_timer_count >= fault_timer_limit))
                         | (fso[FSO_CHAN] & chan_fault);
        end
    end

    // ------------------------------------------------------------
    // pulse test: one millisecond off in every fifty
    // ------------------------------------------------------------
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            pulse_cnt <= 8'h0;
            pulse_off <= 1'b0;
        end else if (ce && tick) begin
            pulse_cnt <= (pulse_cnt == 8'(PULSE_PER_MS - 1)) ? 8'h0 : pulse_cnt + 8'h1;
            pulse_off <= ctrl[CTRL_DO_WIRE] & (pulse_cnt < 8'(PULSE_OFF_MS));
        end
    end

    // readback supervision, sampled on ticks so the load has settled
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            off_settled <= 1'b0;
            stuck_on    <= 1'b0;
            master_open <= 1'b0;
        end else if (ce) begin
            if (do_out) begin
                off_settled <= 1'b0;
            end else if (tick) begin
                off_settled <= 1'b1;
            end
            // set wins over a software clear in the same cycle
            if (tick && pulse_off && do_readback) begin
                stuck_on <= 1'b1;
            end else if (wr_pend && wr_addr == REG_STATUS && hwdata[STATUS_STUCK]) begin
                stuck_on <= 1'b0;
            end
            // latched until reset: a stuck output cannot be trusted again
            if (tick && off_settled && !pulse_off && do_readback) begin
                master_open <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // channel drive and annunciation
    // ------------------------------------------------------------
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            do_out          <= 1'b0;
            master_power_en <= 1'b0;
            do_status       <= '0;
            annunciate      <= 1'b0;
        end else if (ce) begin
            // input statuses deliberately take no part here
            do_out <= cmd_value & !fault_state & !pulse_off & !master_open;
            master_power_en <= !master_open;
            do_status <= chan_fault ? 3'b111 : 3'b000;
            annunciate <= ai_status.bad | di_bad | field_value_bad
                        | chan_fault | stuck_on | master_open;
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    property p_sensor_bad;
        ce && sensor_out |=> ai_status.bad;
    endproperty
    a_sensor_bad: assert property (p_sensor_bad) else $error("sensor limit not bad");

    property p_fault_off;
        ce && fault_state |=> !do_out;
    endproperty
    a_fault_off: assert property (p_fault_off) else $error("output on in fault");

    property p_master;
        ce && master_open |=> !do_out && !master_power_en;
    endproperty
    a_master: assert property (p_master) else $error("master not opened");

    property p_chan_trip;
        ce && chan_fault && fso[FSO_CHAN] |=> fault_state ##1 (!ce || !do_out);
    endproperty
    a_chan_trip: assert property (p_chan_trip) else $error("no immediate trip");

    property p_timer_clear;
        ce && !cmd_bad |=> fault_timer_count == 32'h0;
    endproperty
    a_timer_clear: assert property (p_timer_clear) else $error("timer not cleared");

    property p_do_status;
        ce && chan_fault |=> do_status == 3'b111;
    endproperty
    a_do_status: assert property (p_do_status) else $error("open/short status");

    property p_vote_tol;
        ce && vmode == VOTE_2OO3 && $countones(vote_bad) == 1 |=> !voter_bad;
    endproperty
    a_vote_tol: assert property (p_vote_tol) else $error("2oo3 went bad");

    property p_effect;
        ce && (cem_map[3:0] & cause_bad) != 4'h0 |=> effect_bad[0];
    endproperty
    a_effect: assert property (p_effect) else $error("effect not bad");

    property p_drive;
        ce && cmd_value && !fault_state && !pulse_off && !master_open |=> do_out;
    endproperty
    a_drive: assert property (p_drive) else $error("output dropped");

endmodule : cfstl_top

// ---- hdl/cfstl_pkg.sv ----
package cfstl_pkg;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int unsigned CLK_HZ         = 125_000_000;
    localparam int unsigned TICK_MS        = 1;
    localparam int unsigned TICK_CYCLES    = CLK_HZ / 1000 * TICK_MS;
    localparam int unsigned CLAMP_QUAL_S   = 4;
    localparam int unsigned CLAMP_QUAL_MS  = CLAMP_QUAL_S * 1000;
    localparam int unsigned FT_LIMIT_S     = 300;
    localparam int unsigned PULSE_OFF_MS   = 1;
    localparam int unsigned PULSE_PER_MS   = 50;

    // ------------------------------------------------------------
    // loop current limits in microamps
    // ------------------------------------------------------------
    localparam logic [15:0] SENSOR_LO_UA   = 16'h030c; // 0.78 mA
    localparam logic [15:0] SENSOR_HI_UA   = 16'h5884; // 22.66 mA
    localparam logic [15:0] CLAMP_LO_UA    = 16'h0e10; // 3.6 mA
    localparam logic [15:0] CLAMP_HI_UA    = 16'h5208; // 21.0 mA

    // ------------------------------------------------------------
    // register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] REG_CTRL        = 8'h00;
    localparam logic [7:0] REG_RANGE       = 8'h04;
    localparam logic [7:0] REG_DIAG_MASK   = 8'h08;
    localparam logic [7:0] REG_FT_LIMIT    = 8'h0c;
    localparam logic [7:0] REG_CEM_MAP     = 8'h10;
    localparam logic [7:0] REG_STATUS      = 8'h14;
    localparam logic [7:0] REG_FT_COUNT    = 8'h18;

    // ------------------------------------------------------------
    // control fields and reset values
    // ------------------------------------------------------------
    localparam int CTRL_CLAMP_EN  = 0;
    localparam int CTRL_BAD_LIM   = 1;
    localparam int CTRL_DI_WIRE   = 2;
    localparam int CTRL_DO_WIRE   = 3;
    localparam int CTRL_FSO_LO    = 4;
    localparam int CTRL_VMODE_LO  = 6;
    localparam int CTRL_VSOPT     = 8;
    localparam int CTRL_W         = 9;
    localparam int FSO_CMD        = 0;
    localparam int FSO_CHAN       = 1;
    localparam logic [8:0]  CTRL_RST      = 9'h028; // do wiring, chan detect
    localparam logic [15:0] HI_PCT_RST    = 16'h2af8; // 110.00 %
    localparam logic [15:0] LO_PCT_RST    = 16'hfc18; // -10.00 %
    localparam logic [7:0]  DIAG_MASK_RST = 8'h00;
    localparam logic [31:0] FT_LIMIT_RST  = 32'(FT_LIMIT_S * 1000);
    localparam logic [15:0] CEM_MAP_RST   = 16'h0000;
    localparam int STATUS_STUCK   = 14;

    typedef enum logic [1:0] {
        VOTE_1OO1 = 2'b00,
        VOTE_1OO2 = 2'b01,
        VOTE_2OO2 = 2'b10,
        VOTE_2OO3 = 2'b11
    } cfstl_vote_e;

    typedef struct packed {
        logic bad;
        logic high_lim;
        logic low_lim;
    } cfstl_ai_stat_s;

    typedef struct packed {
        logic bad;
        logic sensor_fail;
        logic low_lim;
    } cfstl_do_stat_s;

endpackage : cfstl_pkg

// ---- test/cfstl_field.sv ----
`timescale 1ns/1ps
module cfstl_field (
    input  wire logic do_out,
    input  wire logic stuck,
    input  wire logic brk,
    output logic      do_readback,
    output logic      do_open
);
    // a welded contact keeps readback high after the drive drops
    assign do_readback = do_out | stuck;
    // broken wire is a level for as long as it lasts
    assign do_open     = brk;
endmodule : cfstl_field

// ---- test/tb_channel_fault_status_trip_logic.sv ----
`timescale 1ns/1ps
module tb_channel_fault_status_trip_logic;
    import cfstl_pkg::*;
    logic           clk, sys_rst, hwrite, hrdy, stuck, brk, dic, diw, cv, cb;
    logic           rb, dopen, aib, fvb, dib, vo, vb, dout, mpe, ann, hrsp;
    logic [1:0]     htrans;
    logic [31:0]    haddr, hwdata, hrdata, rd, seed;
    logic [15:0]    cur, pct;
    logic [7:0]     diag;
    logic [2:0]     vt, vbad;
    logic [3:0]     ct, eo, eb;
    cfstl_ai_stat_s ais;
    cfstl_do_stat_s dos;
    logic [31:0]    exp_q[$];
    logic [31:0]    got_q[$];
    int             fails, checked, n;
    event           seen;

    // short tick keeps the 4 s clamp window near 40k cycles
    cfstl_top #(.TICK_LEN(10)) u_cfstl_top (.clk(clk), .sys_rst(sys_rst), .ce(1'b1),
        .hsel(1'b1), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
        .hwdata(hwdata), .hready(hrdy), .hrdata(hrdata), .hreadyout(hrdy), .hresp(hrsp),
        .ai_current_ua(cur), .ai_value_pct(pct), .field_diag(diag),
        .di_circuit_fault(dic), .di_wire_fault(diw), .vote_trip(vt), .vote_bad(vbad),
        .cause_trip(ct), .cmd_value(cv), .cmd_bad(cb), .do_open(dopen), .do_short(1'b0),
        .do_readback(rb), .ai_status(ais), .ai_block_bad(aib), .field_value_bad(fvb),
        .di_bad(dib), .voter_out(vo), .voter_bad(vb), .effect_out(eo), .effect_bad(eb),
        .do_status(dos), .do_out(dout), .master_power_en(mpe), .annunciate(ann));
    cfstl_field u_cfstl_field (.do_out(dout), .stuck(stuck), .brk(brk),
        .do_readback(rb), .do_open(dopen));

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    function automatic logic [31:0] lf(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lf
    task cy(input int k);
        repeat (k) @(posedge clk);
    endtask : cy
    task end_of_test();
        #1;
        $display("checked %0d fails %0d", checked, fails);
        if (fails == 0 && checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : end_of_test
    // bounded wait for hready; a stuck slave ends the run
    task wt();
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (hrdy !== 1'b1 && n < 50);
        if (n >= 50) begin
            fails++;
            end_of_test();
        end
    endtask : wt
    task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        htrans <= 2'b10;
        haddr  <= {24'h0, a};
        hwrite <= w;
        wt();
        htrans <= 2'b00;
        hwdata <= d;
        wt();
        rd = hrdata;
    endtask : bus
    task chk(input logic [31:0] e, input logic [31:0] g);
        exp_q.push_back(e);
        got_q.push_back(g);
        -> seen;
    endtask : chk
    // monitor drains every note, so two checks in one step are safe
    always @(seen) begin : mon
        logic [31:0] ex, gv;
        while (exp_q.size() > 0) begin
            ex = exp_q.pop_front();
            gv = got_q.pop_front();
            checked++;
            if (gv !== ex) begin
                fails++;
                $display("BAD t=%0t exp=%h got=%h", $time, ex, gv);
            end
        end
    end

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    initial begin
        {hwrite, stuck, brk, dic, diw, cv, cb, fails, checked} = '0;
        {htrans, haddr, hwdata, pct, diag, vt, vbad, ct} = '0;
        cur = 16'h1000;
        seed = 32'h1bbc;
        sys_rst = 1'b1;
        cy(2);
        sys_rst <= 1'b0;
        cy(2);
        bus(0, REG_CTRL, 0);
        chk(32'h028, rd);
        bus(0, REG_FT_LIMIT, 0);
        chk(32'd300000, rd);
        bus(0, REG_DIAG_MASK, 0);
        chk(0, rd);
        bus(0, 8'h40, 0);
        chk(0, rd);
        chk(0, hrsp);
        $display("test regs done");
        cur <= 16'h030b;
        cy(3);
        chk(1, ais.bad);
        chk(1, ann);
        cur <= 16'h5885;
        cy(3);
        chk(1, ais.bad);
        seed = lf(seed);
        cur <= 16'h1000 + {2'b0, seed[13:0]};
        cy(3);
        chk(0, ais.bad);
        pct <= 16'h2af9;
        cy(3);
        chk(3'b010, ais);
        bus(1, REG_CTRL, 32'h022);
        cy(3);
        chk(1, aib);
        pct <= 16'hfc17;
        cy(3);
        chk(3'b001, ais);
        pct <= 16'h0;
        diag <= 8'h04;
        cy(3);
        chk(0, fvb);
        bus(1, REG_DIAG_MASK, 32'h4);
        cy(3);
        chk(1, fvb);
        $display("test analog done");
        bus(1, REG_CTRL, 32'h020);
        bus(1, REG_CEM_MAP, 32'h202);
        cv <= 1'b1;
        ct <= 4'b0010;
        diw <= 1'b1;
        cy(3);
        chk(0, dib);
        bus(1, REG_CTRL, 32'h024);
        cy(3);
        chk(1, dib);
        chk(4'b0101, eb);
        chk(4'b0101, eo);
        chk(1, dout);
        diw <= 1'b0;
        dic <= 1'b1;
        cy(3);
        chk(1, dib);
        dic <= 1'b0;
        vbad <= 3'b001;
        for (int v = 0; v < 8; v++) begin
            seed = lf(seed);
            vt <= seed[2:0];
            bus(1, REG_CTRL, {23'h0, v[2], v[1:0], 6'h20});
            cy(3);
            chk(!v[0], vb);
        end
        // 2oo3 with option: the bad input adds a trip vote, status stays good
        vt <= 3'b010;
        cy(3);
        chk(1, vo);
        bus(1, REG_CTRL, 32'h0e0);
        cy(3);
        chk(0, vo);
        chk(0, vb);
        vbad <= 3'b000;
        $display("test discrete and voter done");
        bus(1, REG_FT_LIMIT, 32'd5);
        bus(1, REG_CTRL, 32'h030);
        cb <= 1'b1;
        cy(30);
        cb <= 1'b0;
        cy(3);
        bus(0, REG_FT_COUNT, 0);
        chk(0, rd);
        chk(1, dout);
        cb <= 1'b1;
        cy(80);
        chk(0, dout);
        cb <= 1'b0;
        brk <= 1'b1;
        cy(3);
        chk(3'b111, dos);
        chk(0, dout);
        // diagnostic goes quiet: fault state drops by itself
        brk <= 1'b0;
        cy(3);
        chk(1, dout);
        brk <= 1'b1;
        cy(3);
        bus(1, REG_CTRL, 32'h000);
        cy(3);
        chk(1, dout);
        brk <= 1'b0;
        $display("test output fault done");
        bus(1, REG_CTRL, 32'h021);
        cur <= 16'h53fc;
        cy(39000);
        chk(0, ais.bad);
        cy(2000);
        chk(1, ais.bad);
        $display("test clamp done");
        bus(1, REG_CTRL, 32'h028);
        n = 0;
        while (dout !== 1'b0 && n < 700) begin
            cy(1);
            n++;
        end
        chk(0, dout);
        stuck <= 1'b1;
        cy(600);
        bus(0, REG_STATUS, 0);
        chk(1, rd[13]);
        cv <= 1'b0;
        cy(40);
        chk(0, mpe);
        $display("test pulse and readback done");
        end_of_test();
    end
endmodule : tb_channel_fault_status_trip_logic
